// ---- fcc_channel.sv ----
// fcc_channel: one fifo channel with write and read clocks, flags, offset
// registers, three-state read bus control and an avalon-mm status port.
// assumes: inputs meet setup to their own clock; rstn is held low for at
// least two edges of each clock; the bus master sits on wr_clk.
//
// Function
// [R01] reset low returns read and write pointers to the first location
// [R02] controller resets the channel after power-up before any write
// [R03] reset drives full and almost-full high, empty and almost-empty low
// [R04] reset clears the output register and loads default offsets
// [R05] writes start on rising wr_clk; full flags update on wr_clk
// [R06] works with unrelated or identical write and read clocks
// [R07] flag mode: first write enable low alone stores a word each edge
// [R08] without a valid write the input side takes no new word
// [R09] full drives full_n low and blocks writes until a read frees room
// [R10] both read enables low moves the next word into the output register
// [R11] either read enable high holds the output register
// [R12] empty drives empty_n low and blocks reads until a write arrives
// [R13] empty and almost-empty flags update on rd_clk
// [R14] out_drive_n low drives rd_data, high releases the bus
// [R15] load pin sampled during reset: high two enables, low flag mode
// [R16] two enable mode stores only with first low and second high
// [R17] four 8-bit offset registers, loaded from inputs, read on outputs
// [R18] load and first enable low write the four offsets in turn, wrapping
// [R19] raising load keeps the sequence place for the next load
// [R20] offset reads follow the same order on rd_clk with load low
// [R21] unprogrammed thresholds are empty plus seven and full minus seven
// [R22] empty asserts when read pointer equals write pointer
// [R23] almost-empty low while count at most empty offset
// [R24] controller never reads and writes offsets in the same cycle
// [R25] almost-full low while count at least depth minus full offset
// [R26] cross-domain flags use gray pointers through two flip-flops
`timescale 1ns/10ps
`default_nettype none

module fcc_channel #(
   parameter int DEPTH = fcc_pkg::DEPTH_DEF
) (
   // clocks and reset
   input wire logic wr_clk,
   input wire logic rd_clk,
   input wire logic rstn,
   // write port
   input wire logic [fcc_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en_first_n,
   input wire logic wr_en_second_or_load,
   output logic full_n,
   output logic almost_full_n,
   // read port
   input wire logic rd_en_first_n,
   input wire logic rd_en_second_n,
   input wire logic out_drive_n,
   output logic [fcc_pkg::DATA_W-1:0] rd_data,
   output logic rd_data_oe,
   output logic empty_n,
   output logic almost_empty_n,
   // avalon-mm slave on wr_clk
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest
);

   // ==========================================================
   // sizes
   localparam int AW = $clog2(DEPTH);
   localparam int CW = AW + 1;

   // gray to binary, one bit folded in per step
   function automatic logic [CW-1:0] g2b(input logic [CW-1:0] g);
      logic [CW-1:0] b;
      b = g;
      for (int i = CW - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // ==========================================================
   // state
   logic [fcc_pkg::DATA_W-1:0] mem [DEPTH];
   logic [fcc_pkg::OFS_W-1:0] ofs_r [fcc_pkg::NUM_OFS];
   logic two_we_r;
   logic inhibit_r;
   logic [CW-1:0] wbin_r, wgray_r, rbin_r, rgray_r;
   logic [CW-1:0] rq1_r, rq2_r, wq1_r, wq2_r;
   logic [CW-1:0] wcnt_r;
   fcc_pkg::fcc_wr_flags_t wflag_r;
   fcc_pkg::fcc_rd_flags_t rflag_r;
   fcc_pkg::fcc_ofs_sel_t wr_sel_r, rd_sel_r;
   logic [fcc_pkg::DATA_W-1:0] rd_data_r;
   logic mode_s1_r, mode_s2_r, load_s1_r, load_s2_r;
   logic ack_r;
   logic [31:0] avs_readdata_r;

   // ==========================================================
   // write side decode
   logic load_n;
   logic wr_qual, wr_fire, ofs_wr;
   logic [CW-1:0] wbin_nxt, rbin_w, wcnt_nxt;
   logic [15:0] full_ofs, empty_ofs;
   logic [17:0] af_sum;

   assign load_n = wr_en_second_or_load;
   assign full_ofs = {ofs_r[fcc_pkg::OFS_FULL_HI], ofs_r[fcc_pkg::OFS_FULL_LO]};
   assign empty_ofs = {ofs_r[fcc_pkg::OFS_EMPTY_HI], ofs_r[fcc_pkg::OFS_EMPTY_LO]};

   // [R07] [R16] write qualifiers by mode
   assign wr_qual = two_we_r ? (!wr_en_first_n && wr_en_second_or_load)
                             : (!wr_en_first_n && load_n);
   // [R09] full blocks every word write, not offset loads; bus inhibit also drops writes without lowering full_n
   assign wr_fire = wr_qual && wflag_r.full_n && !inhibit_r;
   // [R18] offset load strobe in flag mode
   assign ofs_wr = !two_we_r && !load_n && !wr_en_first_n;

   // [R05] pointer and word count as seen after this edge
   assign wbin_nxt = wr_fire ? CW'(wbin_r + 1'b1) : wbin_r;
   assign rbin_w = g2b(rq2_r);
   assign wcnt_nxt = CW'(wbin_nxt - rbin_w);
   assign af_sum = 18'(wcnt_nxt) + 18'(full_ofs);

   // [R15] mode strap caught by the clock while reset is low
   always_ff @(posedge wr_clk) begin
      if (!rstn) begin
         two_we_r <= wr_en_second_or_load;
      end
   end

   // [R01] write pointer, binary and gray
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         wbin_r <= '0;
         wgray_r <= '0;
      end else begin
         wbin_r <= wbin_nxt;
         wgray_r <= wbin_nxt ^ (wbin_nxt >> 1);
      end
   end

   // [R08] storage row written only on an accepted word
   always_ff @(posedge wr_clk) begin
      if (wr_fire) begin
         mem[wbin_r[AW-1:0]] <= wr_data;
      end
   end

   // [R06] [R26] read pointer into write domain, two flip-flops
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         rq1_r <= '0;
         rq2_r <= '0;
      end else begin
         rq1_r <= rgray_r;
         rq2_r <= rq1_r;
      end
   end

   // [R03] [R25] full flags; reads seen late make full stay conservative
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         wflag_r <= fcc_pkg::WR_FLAGS_RST;
         wcnt_r <= '0;
      end else begin
         wflag_r.full_n <= (wcnt_nxt != CW'(DEPTH));
         wflag_r.almost_full_n <= (af_sum < 18'(DEPTH));
         wcnt_r <= wcnt_nxt;
      end
   end

   // [R04] [R21] offsets default to seven; [R18] [R19] sequence kept across loads
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         ofs_r[fcc_pkg::OFS_EMPTY_LO] <= fcc_pkg::EMPTY_OFS_LO_DEF;
         ofs_r[fcc_pkg::OFS_EMPTY_HI] <= fcc_pkg::EMPTY_OFS_HI_DEF;
         ofs_r[fcc_pkg::OFS_FULL_LO] <= fcc_pkg::FULL_OFS_LO_DEF;
         ofs_r[fcc_pkg::OFS_FULL_HI] <= fcc_pkg::FULL_OFS_HI_DEF;
         wr_sel_r <= fcc_pkg::OFS_EMPTY_LO;
      end else if (ofs_wr) begin
         // [R17] low eight data bits load the selected offset
         ofs_r[wr_sel_r] <= wr_data[fcc_pkg::OFS_W-1:0];
         wr_sel_r <= fcc_pkg::fcc_ofs_sel_t'(wr_sel_r + 2'd1);
      end
   end

   assign full_n = wflag_r.full_n;
   assign almost_full_n = wflag_r.almost_full_n;

   // ==========================================================
   // read side
   logic rd_go, ofs_rd, rd_fire;
   logic [CW-1:0] rbin_nxt, wbin_r2, rcnt_nxt;
   logic [CW-1:0] rgray_nxt;

   // mode and load pin into read domain; only the second stage is used
   always_ff @(posedge rd_clk or negedge rstn) begin
      if (!rstn) begin
         mode_s1_r <= 1'b0;
         mode_s2_r <= 1'b0;
         load_s1_r <= 1'b1;
         load_s2_r <= 1'b1;
      end else begin
         mode_s1_r <= two_we_r;
         mode_s2_r <= mode_s1_r;
         load_s1_r <= load_n;
         load_s2_r <= load_s1_r;
      end
   end

   assign rd_go = !rd_en_first_n && !rd_en_second_n;
   // [R20] offset read when flag mode and load low
   assign ofs_rd = rd_go && !mode_s2_r && !load_s2_r;
   // [R12] empty blocks every word read; offset reads still run while empty
   assign rd_fire = rd_go && !ofs_rd && rflag_r.empty_n;

   // [R13] pointer and count after this edge
   assign rbin_nxt = rd_fire ? CW'(rbin_r + 1'b1) : rbin_r;
   assign rgray_nxt = rbin_nxt ^ (rbin_nxt >> 1);
   assign wbin_r2 = g2b(wq2_r);
   assign rcnt_nxt = CW'(wbin_r2 - rbin_nxt);

   // [R01] read pointer, binary and gray
   always_ff @(posedge rd_clk or negedge rstn) begin
      if (!rstn) begin
         rbin_r <= '0;
         rgray_r <= '0;
      end else begin
         rbin_r <= rbin_nxt;
         rgray_r <= rgray_nxt;
      end
   end

   // [R26] write pointer into read domain, two flip-flops
   always_ff @(posedge rd_clk or negedge rstn) begin
      if (!rstn) begin
         wq1_r <= '0;
         wq2_r <= '0;
      end else begin
         wq1_r <= wgray_r;
         wq2_r <= wq1_r;
      end
   end

   // [R22] [R23] [R03] empty flags; writes seen late keep empty conservative
   always_ff @(posedge rd_clk or negedge rstn) begin
      if (!rstn) begin
         rflag_r <= fcc_pkg::RD_FLAGS_RST;
      end else begin
         rflag_r.empty_n <= (rgray_nxt != wq2_r);
         rflag_r.almost_empty_n <= (18'(rcnt_nxt) > 18'(empty_ofs));
      end
   end

   // [R10] [R11] [R04] output register; offsets are quasi-static here
   always_ff @(posedge rd_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_r <= fcc_pkg::DATA_RST;
         rd_sel_r <= fcc_pkg::OFS_EMPTY_LO;
      end else if (ofs_rd) begin
         // [R20] read sequence advances in load order
         rd_data_r <= fcc_pkg::DATA_W'(ofs_r[rd_sel_r]);
         rd_sel_r <= fcc_pkg::fcc_ofs_sel_t'(rd_sel_r + 2'd1);
      end else if (rd_fire) begin
         rd_data_r <= mem[rbin_r[AW-1:0]];
      end
   end

   // [R14] bus drive follows out_drive_n directly
   assign rd_data = rd_data_r;
   assign rd_data_oe = !out_drive_n;
   assign empty_n = rflag_r.empty_n;
   assign almost_empty_n = rflag_r.almost_empty_n;

   // ==========================================================
   // avalon slave: one wait cycle, answer on the second edge
   logic bus_req;
   logic [31:0] status_word;

   assign bus_req = avs_read || avs_write;
   assign avs_waitrequest = bus_req && !ack_r;
   assign avs_readdata = avs_readdata_r;

   always_comb begin
      status_word = fcc_pkg::BUS_ZERO;
      status_word[fcc_pkg::ST_FULL_BIT] = wflag_r.full_n;
      status_word[fcc_pkg::ST_AFULL_BIT] = wflag_r.almost_full_n;
      status_word[fcc_pkg::ST_MODE_BIT] = two_we_r;
      status_word[fcc_pkg::ST_INHIBIT_BIT] = inhibit_r;
      status_word[fcc_pkg::ST_COUNT_LSB +: CW] = wcnt_r;
   end

   // ack pulses one cycle after a request is seen, then drops
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req && !ack_r;
      end
   end

   // write inhibit, low byte lane only
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         inhibit_r <= 1'b0;
      end else if (avs_write && ack_r && avs_byteenable[0]
                   && avs_address == fcc_pkg::ADDR_CTRL) begin
         inhibit_r <= avs_writedata[fcc_pkg::CTRL_INHIBIT_BIT];
      end
   end

   // read data registered at ack, unmapped reads give zero
   always_ff @(posedge wr_clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata_r <= fcc_pkg::BUS_ZERO;
      end else if (avs_read && !ack_r) begin
         case (avs_address)
            fcc_pkg::ADDR_CTRL: begin
               avs_readdata_r <= 32'(inhibit_r);
            end
            fcc_pkg::ADDR_STATUS: begin
               avs_readdata_r <= status_word;
            end
            fcc_pkg::ADDR_OFFSETS: begin
               avs_readdata_r <= {full_ofs, empty_ofs};
            end
            default: begin
               avs_readdata_r <= fcc_pkg::BUS_ZERO;
            end
         endcase
      end
   end

   // ==========================================================
   // assertions
   // [R01] write pointer and full flags at reset value after release
   a_reset_state: assert property (@(posedge wr_clk) disable iff (!rstn) // [R01] [R03]
      ($past(rstn) == 1'b0) |-> (wbin_r == '0 && wflag_r.full_n
                                 && wflag_r.almost_full_n))
      else $error("write side not at reset state after release");

   // [R09] full blocks writes
   a_full_blocks: assert property (@(posedge wr_clk) disable iff (!rstn) // [R09]
      !wflag_r.full_n |=> (wbin_r == $past(wbin_r)))
      else $error("write pointer moved while full");

   // [R07] accepted word advances pointer by one
   a_write_step: assert property (@(posedge wr_clk) disable iff (!rstn) // [R07]
      wr_fire |=> (wbin_r == CW'($past(wbin_r) + 1'b1)))
      else $error("write pointer did not step by one");

   // [R16] two enable mode gating
   a_two_we_gate: assert property (@(posedge wr_clk) disable iff (!rstn) // [R16]
      (two_we_r && (wr_en_first_n || !wr_en_second_or_load))
      |=> $stable(wbin_r))
      else $error("write taken without both enables");

   // [R18] offset sequence steps once per load edge
   a_ofs_seq: assert property (@(posedge wr_clk) disable iff (!rstn) // [R18]
      ofs_wr |=> (wr_sel_r == fcc_pkg::fcc_ofs_sel_t'($past(wr_sel_r) + 2'd1)))
      else $error("offset load sequence did not advance");

   // [R12] empty blocks reads
   a_empty_blocks: assert property (@(posedge rd_clk) disable iff (!rstn) // [R12]
      !rflag_r.empty_n |=> (rbin_r == $past(rbin_r)))
      else $error("read pointer moved while empty");

   // [R11] enable high holds output
   a_read_hold: assert property (@(posedge rd_clk) disable iff (!rstn) // [R11]
      (rd_en_first_n || rd_en_second_n) |=> $stable(rd_data_r))
      else $error("output register changed without read");

   // [R22] not empty implies pointers differ
   a_empty_match: assert property (@(posedge rd_clk) disable iff (!rstn) // [R22]
      rflag_r.empty_n |-> (rgray_r != wq2_r))
      else $error("empty_n high with equal pointers");

   // bus answers within two cycles
   a_bus_answer: assert property (@(posedge wr_clk) disable iff (!rstn)
      (bus_req && avs_waitrequest) |=> !avs_waitrequest)
      else $error("bus request not answered in one wait cycle");

endmodule

`default_nettype wire

// ---- fcc_pkg.sv ----
// fcc_pkg: constants, types and bus map for one dual clock fifo channel.
// assumes: included first in compile order; nothing is imported, use fcc_pkg::name.
`default_nettype none

package fcc_pkg;

   // ==========================================================
   // data path and storage
   localparam int DATA_W = 9;          // word width on wr_data and rd_data
   localparam int OFS_W = 8;           // width of each offset register
   localparam int DEPTH_DEF = 256;     // words of storage, smallest member
   localparam int NUM_OFS = 4;         // offset registers per channel

   // ==========================================================
   // offset register reset values: empty+7 and full-7
   localparam logic [7:0] EMPTY_OFS_LO_DEF = 8'h07;
   localparam logic [7:0] EMPTY_OFS_HI_DEF = 8'h00;
   localparam logic [7:0] FULL_OFS_LO_DEF = 8'h07;
   localparam logic [7:0] FULL_OFS_HI_DEF = 8'h00;
   localparam logic [8:0] DATA_RST = 9'h000;

   // ==========================================================
   // offset register order, shared by load and read sequences
   typedef enum logic [1:0] {
      OFS_EMPTY_LO,
      OFS_EMPTY_HI,
      OFS_FULL_LO,
      OFS_FULL_HI
   } fcc_ofs_sel_t;

   // ==========================================================
   // flag bundles, all active low as on the pins
   typedef struct packed {
      logic full_n;
      logic almost_full_n;
   } fcc_wr_flags_t;

   typedef struct packed {
      logic empty_n;
      logic almost_empty_n;
   } fcc_rd_flags_t;

   localparam fcc_wr_flags_t WR_FLAGS_RST = '{full_n: 1'b1, almost_full_n: 1'b1};
   localparam fcc_rd_flags_t RD_FLAGS_RST = '{empty_n: 1'b0, almost_empty_n: 1'b0};

   // ==========================================================
   // avalon register map, byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h4;
   localparam logic [3:0] ADDR_OFFSETS = 4'h8;
   localparam int CTRL_INHIBIT_BIT = 0;
   localparam int ST_FULL_BIT = 0;
   localparam int ST_AFULL_BIT = 1;
   localparam int ST_MODE_BIT = 2;
   localparam int ST_INHIBIT_BIT = 3;
   localparam int ST_COUNT_LSB = 16;
   localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

endpackage

`default_nettype wire

// ---- fcc_partner.sv ----
// fcc_partner: producer on the write port, consumer on the read port.
// assumes: the bench calls one task at a time and feeds back the resolved read bus.
`timescale 1ns/10ps
`default_nettype none
module fcc_partner (
   // clocks
   input wire logic wr_clk,
   input wire logic rd_clk,
   // resolved read bus
   input wire logic [8:0] rd_bus,
   // write side
   output var logic [8:0] wr_data,
   output var logic wr_en_first_n,
   output var logic load_pin,
   // read side
   output var logic rd_en_first_n,
   output var logic rd_en_second_n
);
   // ==========================================================
   // idle levels from time zero
   initial begin
      wr_data = 9'h000;
      wr_en_first_n = 1'b1;
      load_pin = 1'b0;
      rd_en_first_n = 1'b1;
      rd_en_second_n = 1'b1;
   end
   // strap level, set on the edge where reset is driven low and held through it
   task automatic strap(input logic v);
      @(posedge wr_clk);
      load_pin <= v;
   endtask
   // one write edge; pin low in flag mode loads an offset
   task automatic put(input logic [8:0] d, input logic pin_v);
      @(posedge wr_clk);
      wr_data <= d;
      wr_en_first_n <= 1'b0;
      load_pin <= pin_v;
   endtask
   // release; data inverted so a stale word never looks fresh
   task automatic rest();
      @(posedge wr_clk);
      wr_data <= ~wr_data;
      wr_en_first_n <= 1'b1;
      load_pin <= 1'b1;
   endtask
   // reads only run between write bursts, never beside a load
   task automatic pop(input logic e2, output logic [8:0] d);
      @(posedge rd_clk);
      rd_en_first_n <= 1'b0;
      rd_en_second_n <= e2;
      @(posedge rd_clk);
      rd_en_first_n <= 1'b1;
      rd_en_second_n <= 1'b1;
      @(negedge rd_clk);
      d = rd_bus;
   endtask
endmodule
`default_nettype wire

// ---- fcc_channel_bench.sv ----
// fcc_channel_bench: self-checking bench for one fifo channel.
// assumes: fcc_pkg and fcc_channel compiled first; depth cut to 16 words.
`timescale 1ns/10ps
`default_nettype none
module fcc_channel_bench;
   localparam int DEPTH = 16;
   // ==========================================================
   // stimulus and observed signals
   logic wr_clk = 1'b0;
   logic rd_clk = 1'b0;
   logic rstn = 1'b0;
   logic out_drive_n = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   wire logic [8:0] wr_data;
   wire logic wr_en_first_n;
   wire logic load_pin;
   wire logic rd_en_first_n;
   wire logic rd_en_second_n;
   logic [8:0] rd_data;
   logic rd_data_oe;
   logic full_n;
   logic almost_full_n;
   logic empty_n;
   logic almost_empty_n;
   int miscompares = 0;
   int comparisons = 0;
   // three-state read bus as seen on the board
   wire logic [8:0] rd_bus = rd_data_oe ? rd_data : 9'hzzz;
   // unrelated clocks: 10 ns write side, 14 ns read side
   always #5 wr_clk = ~wr_clk;
   always #7 rd_clk = ~rd_clk;
   // ==========================================================
   // design and far side
   fcc_channel #(.DEPTH(DEPTH)) dut (
      .wr_clk(wr_clk), .rd_clk(rd_clk), .rstn(rstn), .wr_data(wr_data),
      .wr_en_first_n(wr_en_first_n), .wr_en_second_or_load(load_pin),
      .full_n(full_n), .almost_full_n(almost_full_n), .rd_en_first_n(rd_en_first_n),
      .rd_en_second_n(rd_en_second_n), .out_drive_n(out_drive_n), .rd_data(rd_data),
      .rd_data_oe(rd_data_oe), .empty_n(empty_n), .almost_empty_n(almost_empty_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_byteenable(4'hf), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   fcc_partner partner (
      .wr_clk(wr_clk), .rd_clk(rd_clk), .rd_bus(rd_bus), .wr_data(wr_data),
      .wr_en_first_n(wr_en_first_n), .load_pin(load_pin),
      .rd_en_first_n(rd_en_first_n), .rd_en_second_n(rd_en_second_n));
   // ==========================================================
   // shared helpers
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   // avalon master: holds the request until waitrequest is seen low
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                      output logic [31:0] d);
      int n;
      n = 0;
      @(posedge wr_clk);
      avs_address <= a;
      avs_read <= !wr;
      avs_write <= wr;
      avs_writedata <= wd;
      do begin
         @(posedge wr_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50) miscompares++;
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   // back-to-back words, then time for flags to cross
   task automatic fill(input logic [8:0] base, input int n);
      for (int i = 0; i < n; i++) partner.put(base + 9'(i), 1'b1);
      partner.rest();
      repeat (6) @(posedge rd_clk);
      @(negedge rd_clk);
   endtask
   // strap level and reset low are both set on the same wr_clk edge
   task automatic do_reset(input logic mode);
      partner.strap(mode);
      rstn <= 1'b0;
      repeat (10) @(posedge wr_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge rd_clk);
      @(negedge rd_clk);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      chk("full_n", 32'h1, full_n);
      chk("almost_full_n", 32'h1, almost_full_n);
      chk("empty_n", 32'h0, empty_n);
      chk("almost_empty_n", 32'h0, almost_empty_n);
      chk("rd_bus", 32'h0, rd_bus);
      $display("test reset done");
   endtask
   // default offsets read back in order, load pin low since reset
   task automatic t_ofs_read();
      logic [8:0] q;
      for (int i = 0; i < 8; i++) begin
         partner.pop(1'b0, q);
         chk("offset", (i % 2 == 0) ? 32'h7 : 32'h0, q);
      end
      $display("test offset read done");
   endtask
   // pin raised between loads, sequence must carry on
   task automatic t_ofs_load();
      logic [8:0] v [4] = '{9'h003, 9'h000, 9'h004, 9'h000};
      logic [31:0] d;
      for (int i = 0; i < 4; i++) begin
         partner.put(v[i], 1'b0);
         partner.rest();
      end
      bus(1'b0, fcc_pkg::ADDR_OFFSETS, 32'h0, d);
      chk("offsets", 32'h0004_0003, d);
      $display("test offset load done");
   endtask
   // empty offset 3, full offset 4 on a 16 word store
   task automatic t_fill();
      logic [31:0] d;
      fill(9'h001, 3);
      chk("almost_empty_n", 32'h0, almost_empty_n);
      fill(9'h004, 1);
      chk("almost_empty_n", 32'h1, almost_empty_n);
      chk("empty_n", 32'h1, empty_n);
      fill(9'h005, 7);
      chk("almost_full_n", 32'h1, almost_full_n);
      fill(9'h00c, 1);
      chk("almost_full_n", 32'h0, almost_full_n);
      fill(9'h00d, 4);
      chk("full_n", 32'h0, full_n);
      fill(9'h1ff, 1);
      bus(1'b0, fcc_pkg::ADDR_STATUS, 32'h0, d);
      chk("status", 32'h0010_0000, d);
      $display("test fill done");
   endtask
   task automatic t_drain();
      logic [8:0] q;
      for (int i = 1; i <= 16; i++) begin
         partner.pop(1'b0, q);
         chk("word", 32'(i), q);
         if (i == 8) begin
            partner.pop(1'b1, q);
            chk("held", 32'h8, q);
            chk("full_n", 32'h1, full_n);
         end
      end
      repeat (4) @(posedge rd_clk);
      @(negedge rd_clk);
      chk("empty_n", 32'h0, empty_n);
      chk("almost_empty_n", 32'h0, almost_empty_n);
      partner.pop(1'b0, q);
      chk("after empty", 32'h10, q);
      $display("test drain done");
   endtask
   task automatic t_drive();
      @(posedge wr_clk);
      out_drive_n <= 1'b1;
      @(negedge wr_clk);
      chk("rd_bus", {23'h0, 9'hzzz}, rd_bus);
      chk("rd_data_oe", 32'h0, rd_data_oe);
      @(posedge wr_clk);
      out_drive_n <= 1'b0;
      @(negedge wr_clk);
      chk("rd_bus", 32'h10, rd_bus);
      $display("test drive done");
   endtask
   task automatic t_inhibit();
      logic [31:0] d;
      bus(1'b1, fcc_pkg::ADDR_CTRL, 32'h1, d);
      fill(9'h055, 1);
      chk("empty_n", 32'h0, empty_n);
      bus(1'b0, fcc_pkg::ADDR_STATUS, 32'h0, d);
      chk("status", 32'h0000_000b, d);
      bus(1'b1, fcc_pkg::ADDR_CTRL, 32'h0, d);
      bus(1'b0, 4'hc, 32'h0, d);
      chk("unmapped", 32'h0, d);
      $display("test inhibit done");
   endtask
   task automatic t_two_enable();
      logic [31:0] d;
      logic [8:0] q;
      do_reset(1'b1);
      bus(1'b0, fcc_pkg::ADDR_STATUS, 32'h0, d);
      chk("status", 32'h0000_0007, d);
      partner.put(9'h0aa, 1'b0);
      partner.rest();
      repeat (6) @(posedge rd_clk);
      @(negedge rd_clk);
      chk("empty_n", 32'h0, empty_n);
      fill(9'h0bb, 1);
      chk("empty_n", 32'h1, empty_n);
      partner.pop(1'b0, q);
      chk("word", 32'h0bb, q);
      $display("test two enable done");
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      do_reset(1'b0);
      t_reset();
      t_ofs_read();
      t_ofs_load();
      t_fill();
      t_drain();
      t_drive();
      t_inhibit();
      t_two_enable();
      tally_and_finish();
   end
   initial begin
      #200000;
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
